//--- sar_adc_control_map.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_CONTROL_MAP_SVH
`define SAR_ADC_CONTROL_MAP_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define IDX_FLAGS       8'h0C
`define IDX_RESULT      8'h1E
`define IDX_CONTROL_A   8'h1F
`define IDX_PORT_CFG    8'h9F
`define ADDR_W          10

// ==========================================================================
// field positions
`define CLKSEL_HI       7
`define CLKSEL_LO       6
`define CHSEL_HI        5
`define CHSEL_LO        3
`define GO_BIT          2
`define ON_BIT          0
`define PCFG_HI         2
`define PCFG_LO         0
`define DONE_BIT        6

// ==========================================================================
// reset values
`define CONTROL_A_RST   8'h00
`define PORT_CFG_RST    3'h0
`define RESULT_RST      8'h00

// ==========================================================================
// clock codes and timing counts
`define CLK_DIV2        2'h0
`define CLK_DIV8        2'h1
`define CLK_DIV32       2'h2
`define CLK_RC          2'h3
`define HALF_DIV2       5'h00
`define HALF_DIV8       5'h03
`define HALF_DIV32      5'h0F
`define INSTR_CYCLES    3'h4
`define HALF_TADS_CONV  5'h13
`define HALF_TADS_LAST  5'h10
`define HALF_TADS_GAP   3'h4
`define SAR_START       8'h80
`define LAST_CHAN_FIVE  3'h4

`endif

//--- sar_adc_pkg.sv
// types shared by the converter control, the analog source model, the checks and the bench
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RCWAIT = 2'b01,
    ST_CONV   = 2'b10,
    ST_GAP    = 2'b11
  } conv_state_e;

  // everything the analog front end needs from the control logic
  typedef struct packed {
    logic       power;
    logic       sample;
    logic       refExt;
    logic       chanOk;
    logic [2:0] chan;
    logic [7:0] trial;
  } analog_ctl_s;

endpackage

//--- tad_gen.sv
// bit-period generator: one pulse per half bit period from the selected source
`timescale 1ns/1ns
`include "sar_adc_control_map.svh"

module half_period_gen (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [1:0] clkSel,
  input  wire logic       rcTick,
  output logic            halfTick
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] limit;
  logic       wrap;
  logic       tick_next;

  // ==========================================================================
  // divider
  assign limit = (clkSel == `CLK_DIV2) ? `HALF_DIV2 :
                 (clkSel == `CLK_DIV8) ? `HALF_DIV8 : `HALF_DIV32;   // [R4]
  assign wrap      = (cnt_reg == limit);
  assign cnt_next  = (!run || wrap) ? 5'h00 : cnt_reg + 5'h01;
  // rc source ticks already arrive once per half bit period
  assign tick_next = run && ((clkSel == `CLK_RC) ? rcTick : wrap);    // [R4]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 5'h00;
      halfTick <= 1'b0;
    end else if (clkEn) begin
      cnt_reg  <= cnt_next;
      halfTick <= tick_next;
    end
  end

endmodule

//--- sar_adc_control.sv
// converter control: apb registers, conversion sequencer and pin configuration
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "sar_adc_control_map.svh"

// How it works
// [R1] eight trial bits decided by comparator, msb first, into an unsigned result
// [R2] reference is supply or external pin, chosen by the port configuration code
// [R3] conversion continues in sleep only with the internal rc clock
// [R4] clock select: 00 /2, 01 /8, 10 /32, 11 internal rc
// [R5] channel select field routes channel 0 to 7 to the hold
// [R6] channels 5 to 7 exist only on the eight-input variant
// [R7] writing go with converter on starts conversion; go reads 1 while busy
// [R8] hardware clears go when conversion completes
// [R9] converter on bit powers the converter; off means no operating current
// [R10] unimplemented control and config bits read as zero
// [R11] config 000 all analog on supply; 001 adds external reference pin
// [R12] 01x drops channels 5-7, 10x keeps 0,1,3, 11x all digital
// [R13] software clears done flag before enabling the interrupt chain
// [R14] software configures, powers up and waits acquisition before go
// [R15] software polls go or takes interrupt, then reads result
// [R16] at least two bit periods between conversion end and next acquisition
// [R17] software waits acquisition time after changing channel
// [R18] sixteen microseconds suffice for sources up to ten kilohms
// [R19] without converter, registers are absent and flags stay clear
// [R20] clearing go mid-conversion aborts and keeps the old result
// [R21] a conversion lasts nine and a half bit periods
// [R22] with rc clock, one instruction cycle passes before converting
// [R23] reset disables converter and aborts any conversion
// [R24] result load, done flag set and go clear share one cycle
module sar_adc_control #(
  parameter bit HAS_ADC    = 1'b1,
  parameter bit EIGHT_CHAN = 1'b1
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  clkEn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`ADDR_W-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rcTick,
  input  wire logic                  cpuSleep,
  input  wire logic                  compIn,
  output sar_adc_pkg::analog_ctl_s   analogCtl,
  output logic      [7:0]            pinAnalog
);

  sar_adc_pkg::conv_state_e state_reg;
  sar_adc_pkg::conv_state_e state_next;
  logic [1:0]  clkSel_reg;
  logic [2:0]  chSel_reg;
  logic        on_reg;
  logic        go_reg;
  logic        go_next;
  logic        done_reg;
  logic [2:0]  pcfg_reg;
  logic [7:0]  result_reg;
  logic [7:0]  sar_reg;
  logic [7:0]  sar_next;
  logic [4:0]  step_reg;
  logic [4:0]  step_next;
  logic [2:0]  wait_reg;
  logic [2:0]  wait_next;
  logic        halfTick;

  // ==========================================================================
  // functions
  // analog mask ch0..ch7 in bits 0..7, external reference in bit 8
  function automatic logic [8:0] pinRoles(input logic [2:0] cfg, input logic eight);
    logic [7:0] mask;
    mask = 8'h00;
    case (cfg[2:1])
      2'b00:   mask = cfg[0] ? 8'hF7 : 8'hFF;            // [R11]
      2'b01:   mask = cfg[0] ? 8'h17 : 8'h1F;            // [R12]
      2'b10:   mask = cfg[0] ? 8'h03 : 8'h0B;            // [R12]
      default: mask = 8'h00;                             // [R12]
    endcase
    if (!eight) begin
      mask = mask & 8'h1F;                               // [R6]
    end
    pinRoles = {cfg[0] && (cfg[2:1] != 2'b11), mask};    // [R2]
  endfunction

  // keep the decided bit, raise the next trial bit
  function automatic logic [7:0] sarStep(input logic [7:0] sar, input logic [2:0] ptr,
                                         input logic keep);
    logic [7:0] s;
    s = sar;
    s[ptr] = keep;
    if (ptr != 3'h0) begin
      s[ptr - 3'h1] = 1'b1;
    end
    sarStep = s;
  endfunction

  // ==========================================================================
  // bus decode
  logic [7:0] idx;
  logic       setup;
  logic       wrDone;
  logic       hitFlags;
  logic       hitResult;
  logic       hitCtrl;
  logic       hitCfg;
  logic       mapped;
  logic [7:0] rdByte;
  logic       wrCtrl;
  logic       wrCfg;
  logic       wrResult;
  logic       wrFlags;

  assign idx       = paddr[`ADDR_W-1:2];
  assign setup     = psel && !penable;
  assign wrDone    = psel && penable && pready && pwrite;
  assign hitFlags  = (idx == `IDX_FLAGS);
  assign hitResult = HAS_ADC && (idx == `IDX_RESULT);     // [R19]
  assign hitCtrl   = HAS_ADC && (idx == `IDX_CONTROL_A);  // [R19]
  assign hitCfg    = HAS_ADC && (idx == `IDX_PORT_CFG);   // [R19]
  assign mapped    = hitFlags || hitResult || hitCtrl || hitCfg;
  assign wrCtrl    = wrDone && hitCtrl;
  assign wrCfg     = wrDone && hitCfg;
  assign wrResult  = wrDone && hitResult;
  assign wrFlags   = wrDone && hitFlags && HAS_ADC;
  assign rdByte    = hitCtrl   ? {clkSel_reg, chSel_reg, go_reg, 1'b0, on_reg} :   // [R10]
                     hitCfg    ? {5'h00, pcfg_reg} :                                // [R10]
                     hitResult ? result_reg :
                     hitFlags  ? ({7'h00, done_reg} << `DONE_BIT) : 8'h00;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // sequencer
  logic       rcSel;
  logic       sleepKill;
  logic       goWrite;
  logic       goClear;
  logic       convEnd;
  logic       decide;
  logic [2:0] bitPtr;
  localparam sar_adc_pkg::conv_state_e sarStepHold = sar_adc_pkg::ST_IDLE;

  assign rcSel     = (clkSel_reg == `CLK_RC);
  assign sleepKill = cpuSleep && !rcSel;                            // [R3]
  assign goWrite   = wrCtrl && pwdata[`GO_BIT] && on_reg;           // [R7]
  assign goClear   = (wrCtrl && !pwdata[`GO_BIT]) || !on_reg || sleepKill;  // [R20]
  assign step_next = (state_reg == sarStepHold) ? step_reg : step_reg + 5'h01;
  assign decide    = (state_reg == sar_adc_pkg::ST_CONV) && halfTick && !step_next[0]
                     && (step_next != 5'h00) && (step_next <= `HALF_TADS_LAST);
  assign bitPtr    = 3'(4'h8 - {1'b0, step_next[3:1]} - (step_next[4] ? 4'h8 : 4'h0));
  assign convEnd   = (state_reg == sar_adc_pkg::ST_CONV) && halfTick
                     && (step_next == `HALF_TADS_CONV) && !goClear;     // [R21]

  always_comb begin
    state_next = state_reg;
    go_next    = go_reg;
    sar_next   = sar_reg;
    wait_next  = wait_reg;
    case (state_reg)
      sar_adc_pkg::ST_IDLE: begin
        if (goWrite && !sleepKill) begin
          go_next    = 1'b1;                                        // [R7]
          sar_next   = `SAR_START;
          wait_next  = 3'h0;
          state_next = rcSel ? sar_adc_pkg::ST_RCWAIT : sar_adc_pkg::ST_CONV;  // [R22]
        end
      end
      sar_adc_pkg::ST_RCWAIT: begin
        wait_next = wait_reg + 3'h1;
        if (goClear) begin
          go_next    = 1'b0;                                        // [R20]
          wait_next  = 3'h0;
          state_next = sar_adc_pkg::ST_GAP;
        end else if (wait_next == `INSTR_CYCLES) begin
          state_next = sar_adc_pkg::ST_CONV;                        // [R22]
        end
      end
      sar_adc_pkg::ST_CONV: begin
        wait_next = 3'h0;
        if (goClear) begin
          go_next    = 1'b0;                                        // [R20]
          state_next = sar_adc_pkg::ST_GAP;
        end else if (convEnd) begin
          go_next    = 1'b0;                                        // [R8] [R24]
          state_next = sar_adc_pkg::ST_GAP;
        end else if (decide) begin
          sar_next = sarStep(sar_reg, bitPtr, compIn);              // [R1]
        end
      end
      sar_adc_pkg::ST_GAP: begin
        // a go written during the gap waits here until two bit periods have passed
        if (goWrite) begin
          go_next = 1'b1;
        end else if (goClear) begin
          go_next = 1'b0;
        end
        if (halfTick) begin
          wait_next = wait_reg + 3'h1;
        end
        if (wait_next == `HALF_TADS_GAP) begin                      // [R16]
          wait_next  = 3'h0;
          sar_next   = `SAR_START;
          state_next = !go_next ? sar_adc_pkg::ST_IDLE :
                       rcSel ? sar_adc_pkg::ST_RCWAIT : sar_adc_pkg::ST_CONV;
        end
      end
      default: begin
        state_next = sar_adc_pkg::ST_IDLE;
        go_next    = 1'b0;
      end
    endcase
  end

  // the step counter restarts whenever the sequencer is not converting
  logic [4:0] stepLoad;
  assign stepLoad = (state_reg != sar_adc_pkg::ST_CONV) ? 5'h00 :
                    halfTick ? step_next : step_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= sar_adc_pkg::ST_IDLE;                            // [R23]
      go_reg    <= 1'b0;                                            // [R23]
      sar_reg   <= `SAR_START;
      step_reg  <= 5'h00;
      wait_reg  <= 3'h0;
    end else if (clkEn) begin
      state_reg <= state_next;
      go_reg    <= go_next;
      sar_reg   <= sar_next;
      step_reg  <= stepLoad;
      wait_reg  <= wait_next;
    end
  end

  // ==========================================================================
  // software registers
  logic [7:0] result_next;
  logic       done_next;

  assign result_next = convEnd ? sar_next : wrResult ? pwdata[7:0] : result_reg;  // [R24]
  assign done_next   = convEnd || (wrFlags ? pwdata[`DONE_BIT] : done_reg);        // [R24]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_reg <= 2'(`CONTROL_A_RST >> `CLKSEL_LO);
      chSel_reg  <= 3'h0;
      on_reg     <= 1'b0;                                           // [R23]
      pcfg_reg   <= `PORT_CFG_RST;
      result_reg <= `RESULT_RST;
      done_reg   <= 1'b0;
    end else if (clkEn) begin
      if (wrCtrl) begin
        clkSel_reg <= pwdata[`CLKSEL_HI:`CLKSEL_LO];                // [R4]
        chSel_reg  <= pwdata[`CHSEL_HI:`CHSEL_LO];                  // [R5]
        on_reg     <= pwdata[`ON_BIT];                              // [R9]
      end
      if (wrCfg) begin
        pcfg_reg <= pwdata[`PCFG_HI:`PCFG_LO];                      // [R11]
      end
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  // ==========================================================================
  // analog front end controls
  logic [8:0]               roles;
  logic                     busy;
  sar_adc_pkg::analog_ctl_s ctl_next;

  assign roles          = pinRoles(pcfg_reg, EIGHT_CHAN);
  assign busy           = (state_reg == sar_adc_pkg::ST_RCWAIT) ||
                          (state_reg == sar_adc_pkg::ST_CONV);
  // in sleep without a conversion to finish the converter is off, though on_reg stays set
  assign ctl_next.power = on_reg && (!cpuSleep || (rcSel && busy));        // [R9] [R3]
  assign ctl_next.sample = on_reg && !busy && (state_reg != sar_adc_pkg::ST_GAP);  // [R16]
  assign ctl_next.refExt = roles[8];                                        // [R2]
  assign ctl_next.chanOk = EIGHT_CHAN || (chSel_reg <= `LAST_CHAN_FIVE);    // [R6]
  assign ctl_next.chan   = chSel_reg;                                       // [R5]
  assign ctl_next.trial  = sar_next;                                        // [R1]

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      analogCtl <= '0;
      pinAnalog <= 8'hFF;
    end else if (clkEn) begin
      analogCtl <= ctl_next;
      pinAnalog <= roles[7:0];                                              // [R11]
    end
  end

  half_period_gen u_half_period (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .run      (busy || (state_reg == sar_adc_pkg::ST_GAP)),
    .clkSel   (clkSel_reg),
    .rcTick   (rcTick),
    .halfTick (halfTick)
  );

endmodule

//--- analog_source_model.sv
// partner model: analog pins and comparator behind the converter
`timescale 1ns/1ns

module analog_source_model (
  input  wire sar_adc_pkg::analog_ctl_s analogCtl,
  input  wire logic [63:0]              chanLevel,
  output logic                          compIn
);
  // ==========================================================================
  // comparator
  // unpowered comparator gives no decision, so a stale keep bit cannot pass
  assign compIn = analogCtl.power &&
                  (chanLevel[analogCtl.chan*8 +: 8] >= analogCtl.trial);
endmodule

//--- sar_adc_control_properties.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ns
`include "sar_adc_control_map.svh"

module sar_adc_control_properties #(
  parameter bit HAS_ADC    = 1'b1,
  parameter bit EIGHT_CHAN = 1'b1
) (
  input wire logic                     sys_clk,
  input wire logic                     rstn,
  input wire logic                     clkEn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [`ADDR_W-1:0]       paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     rcTick,
  input wire logic                     cpuSleep,
  input wire logic                     compIn,
  input wire sar_adc_pkg::analog_ctl_s analogCtl,
  input wire logic [7:0]               pinAnalog
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // helper logic
  logic [7:0] idx;
  logic       acc;
  logic       rdAcc;
  logic       wrCfg;
  logic       mapped;
  logic [7:0] ctlSeen_reg;
  logic [2:0] cfgSeen_reg;
  assign idx    = paddr[9:2];
  assign acc    = psel && penable && pready && clkEn;
  assign rdAcc  = acc && !pwrite;
  assign wrCfg  = acc && pwrite && idx == `IDX_PORT_CFG;
  assign mapped = idx == `IDX_FLAGS || idx == `IDX_RESULT ||
                  idx == `IDX_CONTROL_A || idx == `IDX_PORT_CFG;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctlSeen_reg <= 8'h00;
      cfgSeen_reg <= 3'h0;
    end else if (acc && pwrite) begin
      if (idx == `IDX_CONTROL_A) ctlSeen_reg <= pwdata[7:0];
      if (idx == `IDX_PORT_CFG) cfgSeen_reg <= pwdata[2:0];
    end
  end

  function automatic logic [7:0] pinOf(input logic [2:0] c);
    case (c)
      3'h0: pinOf = 8'hFF;
      3'h1: pinOf = 8'hF7;
      3'h2: pinOf = 8'h1F;
      3'h3: pinOf = 8'h17;
      3'h4: pinOf = 8'h0B;
      3'h5: pinOf = 8'h03;
      default: pinOf = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // assertions
  a_unmapped_refused: assert property (
    psel && !penable && clkEn && !mapped |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_ctl_readback: assert property (
    rdAcc && idx == `IDX_CONTROL_A |-> prdata[7:3] == ctlSeen_reg[7:3])
    else $error("clock or channel select readback wrong");
  a_unimpl_zero: assert property (
    rdAcc |-> prdata[31:8] == 24'h0 && !(idx == `IDX_CONTROL_A && prdata[1])
      && !(idx == `IDX_PORT_CFG && prdata[7:3] != 5'h0))
    else $error("unimplemented bit reads nonzero");
  a_pin_roles: assert property (
    wrCfg |=> ##1 pinAnalog == pinOf(cfgSeen_reg))
    else $error("pin roles do not match config code");
  a_ref_select: assert property (
    wrCfg |=> ##1 analogCtl.refExt == (cfgSeen_reg[0] && cfgSeen_reg != 3'h7))
    else $error("reference choice wrong");
  a_power_needs_on: assert property (
    analogCtl.power |-> ctlSeen_reg[0] || $past(ctlSeen_reg[0]))
    else $error("converter powered while off");
  a_reset_off: assert property (
    $rose(rstn) |-> !analogCtl.power && pinAnalog == 8'hFF)
    else $error("converter not disabled by reset");
  a_trial_msb_first: assert property (
    analogCtl.trial != 8'h00 && $past(analogCtl.trial) == 8'h00
      |-> analogCtl.trial == `SAR_START)
    else $error("first trial code is not msb");
  a_chan_exists: assert property (
    analogCtl.power |-> analogCtl.chanOk == (EIGHT_CHAN || analogCtl.chan <= 3'h4))
    else $error("channel existence flag wrong");
endmodule

bind sar_adc_control sar_adc_control_properties #(
  .HAS_ADC(HAS_ADC),
  .EIGHT_CHAN(EIGHT_CHAN)
) props (
  .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rcTick(rcTick), .cpuSleep(cpuSleep), .compIn(compIn),
  .analogCtl(analogCtl), .pinAnalog(pinAnalog)
);

//--- testbench.sv
// self-checking bench for the converter control
`timescale 1ns/1ns
`include "sar_adc_control_map.svh"

module testbench;
  localparam logic [9:0] A_CTL = {`IDX_CONTROL_A, 2'b00};
  localparam logic [9:0] A_CFG = {`IDX_PORT_CFG, 2'b00};
  localparam logic [9:0] A_RES = {`IDX_RESULT, 2'b00};
  localparam logic [9:0] A_FLG = {`IDX_FLAGS, 2'b00};
  localparam logic [63:0] LVL = 64'hFF_C3_80_7F_5A_01_00_A5;
  logic        sys_clk = 1'b0;
  logic        rstn, psel, penable, pwrite, cpuSleep, pready, pslverr, compIn;
  logic        rcTick = 1'b0;
  logic        clkEn = 1'b1;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  pinAnalog;
  logic [1:0]  rcCnt = 2'h0;
  sar_adc_pkg::analog_ctl_s analogCtl;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rcCnt <= (rcCnt == 2'h2) ? 2'h0 : rcCnt + 2'h1;
    rcTick <= (rcCnt == 2'h2);
  end

  sar_adc_control uut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rcTick(rcTick), .cpuSleep(cpuSleep),
    .compIn(compIn), .analogCtl(analogCtl), .pinAnalog(pinAnalog));
  analog_source_model src (.analogCtl(analogCtl), .chanLevel(LVL), .compIn(compIn));

  // ==========================================================================
  // tasks
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, then one idle cycle so strobes never toggle in one step
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic convert(input logic [1:0] cs, input logic [2:0] ch);
    int t0;
    int h;
    h = (cs == 2'h0) ? 1 : (cs == 2'h1) ? 4 : (cs == 2'h2) ? 16 : 3;
    apb(1'b1, A_CTL, {cs, ch, 3'b001});
    repeat (160) @(posedge sys_clk); // acquisition wait
    chk("sampling before go", 1, analogCtl.sample);
    cpuSleep <= (cs == 2'h3);
    apb(1'b1, A_CTL, {cs, ch, 3'b101});
    t0 = cyc;
    do apb(1'b0, A_CTL, 8'h00); while (q[2] !== 1'b0 && cyc - t0 < 900);
    chk("conversion time", 1, (cyc - t0 >= 19 * h - 2) && (cyc - t0 <= 19 * h + 16));
    cpuSleep <= 1'b0;
    apb(1'b0, A_RES, 8'h00);
    chk("result", {24'h0, LVL[ch*8 +: 8]}, q);
    apb(1'b0, A_FLG, 8'h00);
    chk("done flag", 32'h40, q);
    apb(1'b1, A_FLG, 8'h00);
  endtask

  // ==========================================================================
  // sequence
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    final_report();
  end

  initial begin
    {rstn, psel, penable, pwrite, cpuSleep} = 5'h00;
    paddr = 10'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("pins at reset", 8'hFF, pinAnalog);
    apb(1'b0, A_CTL, 8'h00);
    chk("control reset", 32'h0, q);
    apb(1'b1, A_CFG, 8'hFF);
    apb(1'b0, A_CFG, 8'h00);
    chk("config readback", 32'h7, q);
    apb(1'b1, A_CTL, 8'hFE);
    apb(1'b0, A_CTL, 8'h00);
    chk("go with converter off", 32'hF8, q);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_CFG, 8'(i));
      @(negedge sys_clk);
      chk("reference", (i % 2 == 1) && i != 7, analogCtl.refExt);
    end
    apb(1'b1, A_CFG, 8'h00);
    for (int i = 0; i < 8; i++) convert(2'(i % 4), 3'(i));
    apb(1'b1, A_RES, 8'h5A);
    apb(1'b1, A_CTL, 8'h91);
    apb(1'b1, A_CTL, 8'h95);
    repeat (40) @(posedge sys_clk);
    apb(1'b1, A_CTL, 8'h91);
    apb(1'b0, A_CTL, 8'h00);
    chk("abort clears go", 32'h91, q);
    chk("no sampling in gap", 0, analogCtl.sample);
    apb(1'b1, A_CTL, 8'h55);
    repeat (10) @(posedge sys_clk);
    cpuSleep <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, A_CTL, 8'h00);
    chk("sleep aborts fast clock", 32'h51, q);
    cpuSleep <= 1'b0;
    apb(1'b0, A_RES, 8'h00);
    chk("result kept", 32'h5A, q);
    apb(1'b1, A_CTL, 8'h00);
    @(negedge sys_clk);
    chk("power off", 1'b0, analogCtl.power);
    apb(1'b0, 10'h000, 8'h00);
    chk("unmapped read", 32'h0, q);
    apb(1'b1, A_CTL, 8'h81);
    apb(1'b1, A_CTL, 8'h85);
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, A_CTL, 8'h00);
    chk("reset aborts", 32'h0, q);
    apb(1'b1, A_CTL, 8'h01);
    repeat (160) @(posedge sys_clk);
    apb(1'b1, A_CTL, 8'h05);
    clkEn <= 1'b0;
    repeat (50) @(posedge sys_clk);
    clkEn <= 1'b1;
    apb(1'b0, A_CTL, 8'h00);
    chk("go frozen by clock enable", 32'h05, q);
    final_report();
  end
endmodule
